// ---- bench/klp_link_assertions.sv ----
module klp_link_checker (
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 req,
  input  wire klp_pkg::klp_cmd_e    cmd,
  input  wire logic [15:0]          key_sel,
  input  wire logic                 done,
  input  wire klp_pkg::klp_status_t status,
  input  wire logic                 match,
  input  wire logic [7:0]           rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  // ------------------------------------------------------------
  // Link timing
  // ------------------------------------------------------------
  chk_done_latency: assert property (req |-> ##2 done)
    else $error("done not two cycles after req");
  chk_done_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  chk_req_spacing: assert property (req |=> !req)
    else $error("req before done");
  chk_result_hold: assert property (!done |-> $stable(status) && $stable(match) && $stable(rdata))
    else $error("result changed without done");
  // ------------------------------------------------------------
  // Verdicts
  // ------------------------------------------------------------
  chk_transport_refused: assert property ((req && key_sel[15] && cmd != klp_pkg::CMD_GEN_DIGEST)
    |-> ##2 (status == 3'h2))
    else $error("transport selector accepted");
  chk_transport_digest: assert property ((req && key_sel[15] && cmd == klp_pkg::CMD_GEN_DIGEST)
    |-> ##2 (status == 3'h0))
    else $error("transport digest refused");
  chk_read_write_ok: assert property ((req && !key_sel[15] && cmd inside {klp_pkg::CMD_READ,
    klp_pkg::CMD_WRITE}) |-> ##2 (status == 3'h0))
    else $error("read or write refused");
  chk_match_status: assert property (done && match |-> status == 3'h0)
    else $error("match with error status");
  cov_exhausted: cover property (done && status == 3'h1);
  cov_match: cover property (done && match);
  cov_transport: cover property (req && key_sel[15] && cmd == klp_pkg::CMD_GEN_DIGEST);
endmodule : klp_link_checker

// ---- bench/tb.sv ----
`include "klp_defs.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic         ref_clk_i      = 1'b0;
  logic         rst_i          = 1'b1;
  logic         psel           = 1'b0;
  logic         penable        = 1'b0;
  logic         pwrite         = 1'b0;
  logic [7:0]   paddr          = 8'h00;
  logic [31:0]  pwdata         = 32'h0;
  logic         single_use15_i = 1'b0;
  logic [63:0]  read_key_i     = 64'h0FFF_FFFF_FFFF_FFFF; // Only slot 15 copyable
  logic [255:0] digest_i       = '0;
  logic [255:0] slot_data_i    = {8{32'h5A5A_1234}};
  logic [31:0]  prdata, rd;
  logic         pready, pslverr, err, transport_o, f_org, f_gen, f_cmp, f_val;
  logic [3:0]   slot_idx_o;
  logic [15:0]  hash_sel_o;
  logic [255:0] scratch_o;
  logic [127:0] bitmap_o;
  logic [127:0] ref_map = '0;
  logic         run_o, cfg_locked_o;
  int           runs = 0;
  int           fails = 0;
  int           total_checks = 0;

  klp_if lnk ();
  klp_host u_klp_host (.ref_clk_i, .rst_i, .link(lnk), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr);
  klp_device u_klp_device (.ref_clk_i, .rst_i, .link(lnk), .single_use15_i, .read_key_i,
    .digest_i, .slot_data_i, .slot_idx_o, .hash_sel_o, .transport_o, .run_o,
    .scratch_o, .scratch_origin_o(f_org), .scratch_gen_data_o(f_gen),
    .scratch_cmp_only_o(f_cmp), .scratch_valid_o(f_val), .bitmap_o, .cfg_locked_o);
  klp_link_checker u_klp_link_checker (.ref_clk_i, .rst_i, .req(lnk.req), .cmd(lnk.cmd),
    .key_sel(lnk.key_sel), .done(lnk.done), .status(lnk.status), .match(lnk.match),
    .rdata(lnk.rdata));

  // Clock and watchdog
  always #5 ref_clk_i = ~ref_clk_i;
  // Count engine go-ahead pulses
  always @(posedge ref_clk_i) if (run_o === 1'b1) runs++;
  initial begin
    repeat (100000) @(posedge ref_clk_i);
    fails++;
    end_sim();
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim

  task automatic cmp(input logic [255:0] got, input logic [255:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // One APB transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk_i);
  endtask : apb

  // Launch a command and poll status until not busy
  task automatic run(input klp_pkg::klp_cmd_e c, input logic [15:0] sel,
                     input logic [7:0] md, input logic sec, input logic [7:0] val);
    int n;
    n = 0;
    apb(1'b1, `KLP_REG_SEL, {16'h0000, sel});
    apb(1'b1, `KLP_REG_CTRL, {8'h00, val, md, 3'h0, sec, c});
    do begin
      apb(1'b0, `KLP_REG_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 20);
    if (rd[0] !== 1'b0) begin
      fails++;
      end_sim();
    end
  endtask : run

  // Reference: clear first one, byte 0 bit 7 first
  function automatic logic [127:0] use1(input logic [127:0] m);
    for (int k = 0; k < 16; k++)
      for (int b = 7; b >= 0; b--)
        if (m[8*k+b]) begin
          m[8*k+b] = 1'b0;
          return m;
        end
    return m;
  endfunction : use1

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0]          legal [9] = '{8'hFF, 8'h7F, 8'h3F, 8'h1F, 8'h0F, 8'h07, 8'h03, 8'h01, 8'h00};
    klp_pkg::klp_cmd_e   cl [5] = '{klp_pkg::CMD_MAC, klp_pkg::CMD_DERIVE,
      klp_pkg::CMD_GEN_DIGEST, klp_pkg::CMD_MAC_COMPARE, klp_pkg::CMD_MAC};
    logic [15:0]         sl [5] = '{16'h000F, 16'h7FFF, 16'h001F, 16'h0F0F, 16'h000F};
    klp_pkg::klp_status_t exp_st;
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    cmp({cfg_locked_o, bitmap_o}, {1'b0, 128'h0});
    apb(1'b0, 8'h20, 32'h0);
    cmp({err, rd}, {1'b1, 32'h0});
    run(klp_pkg::CMD_MAC, 16'h000F, 8'h00, 1'b0, 8'h00);
    cmp(rd[3:1], `KLP_ST_ORDER);
    foreach (legal[i]) begin
      run(klp_pkg::CMD_CFG_BYTE, 16'h0003, 8'h00, 1'b0, legal[i]);
      cmp(bitmap_o[31:24], legal[i]);
    end
    run(klp_pkg::CMD_CFG_BYTE, 16'h0003, 8'h00, 1'b0, 8'h05);
    cmp({rd[3:1], bitmap_o[31:24]}, {`KLP_ST_BAD_VALUE, 8'h00});
    ref_map = {8'h01, 96'h0, 8'h01, 8'h03, 8'h00};
    for (int k = 0; k < 16; k++) run(klp_pkg::CMD_CFG_BYTE, 16'(k), 8'h00, 1'b0, ref_map[8*k +: 8]);
    run(klp_pkg::CMD_CFG_LOCK, 16'h0000, 8'h00, 1'b0, 8'h00);
    cmp({rd[5], rd[3:1], cfg_locked_o}, {1'b1, `KLP_ST_OK, 1'b1});
    run(klp_pkg::CMD_CFG_BYTE, 16'h0000, 8'h00, 1'b0, 8'hFF);
    cmp(bitmap_o, ref_map);
    run(klp_pkg::CMD_READ, 16'h0001, 8'h00, 1'b0, 8'h00);
    cmp(rd[15:8], 8'h03);
    run(klp_pkg::CMD_MAC, 16'h000F, 8'h00, 1'b0, 8'h00);
    cmp({rd[3:1], bitmap_o}, {`KLP_ST_OK, ref_map});
    single_use15_i <= 1'b1;
    run(klp_pkg::CMD_READ, 16'h000F, 8'h00, 1'b0, 8'h00);
    run(klp_pkg::CMD_WRITE, 16'h000F, 8'h00, 1'b0, 8'h00);
    cmp(bitmap_o, ref_map);
    for (int i = 0; i < 5; i++) begin
      exp_st = (ref_map == 128'h0) ? `KLP_ST_EXHAUSTED : `KLP_ST_OK;
      ref_map = use1(ref_map);
      run(cl[i], sl[i], 8'h00, 1'b0, 8'h00);
      cmp({rd[3:1], hash_sel_o, bitmap_o}, {exp_st, sl[i], ref_map});
    end
    cmp(scratch_o, 256'h0);
    run(klp_pkg::CMD_GEN_DIGEST, 16'h8003, 8'h00, 1'b0, 8'h00);
    cmp({rd[3:1], transport_o, bitmap_o}, {`KLP_ST_OK, 1'b1, ref_map});
    run(klp_pkg::CMD_MAC, 16'h8003, 8'h00, 1'b0, 8'h00);
    cmp(rd[3:1], `KLP_ST_BAD_SEL);
    for (int i = 0; i < 8; i++) begin
      digest_i[32*i +: 32] <= 32'hA000_0000 + 32'(i);
      apb(1'b1, `KLP_REG_RESP_IDX, 32'(i));
      apb(1'b1, `KLP_REG_RESP_DATA, 32'hA000_0000 + 32'(i));
    end
    run(klp_pkg::CMD_MAC_COMPARE, 16'h000E, `KLP_COPY_MODE, 1'b1, 8'h00);
    cmp({rd[4:1], slot_idx_o, f_org, f_gen, f_cmp, f_val}, {1'b1, `KLP_ST_OK, 4'hF, 4'h9});
    cmp(scratch_o, slot_data_i);
    slot_data_i <= {8{32'h3C3C_0F0F}};
    run(klp_pkg::CMD_MAC_COMPARE, 16'h000E, `KLP_COPY_MODE, 1'b0, 8'h00);
    cmp({rd[4:1], slot_idx_o, scratch_o}, {1'b1, `KLP_ST_OK, 4'hE, {8{32'h5A5A_1234}}});
    run(klp_pkg::CMD_MAC_COMPARE, 16'h000E, 8'h00, 1'b1, 8'h00);
    cmp(scratch_o, {8{32'h5A5A_1234}});
    apb(1'b1, `KLP_REG_RESP_IDX, 32'h3);
    apb(1'b1, `KLP_REG_RESP_DATA, 32'hDEAD_0003);
    run(klp_pkg::CMD_MAC_COMPARE, 16'h000E, `KLP_COPY_MODE, 1'b1, 8'h00);
    cmp({rd[4:1], scratch_o}, {1'b0, `KLP_ST_OK, {8{32'h5A5A_1234}}});
    cmp(runs, 32'h7);
    end_sim();
  end
endmodule : tb

// ---- rtl/klp_device.sv ----
// Contract
// - Key-15 limit only when slot 15 single-use set
// - All bitmap bytes zero: key-15 use errors
// - Clear first one, byte 68 bit 7 onward
// - Exactly one bitmap bit cleared per use
// - No restore of bitmap bits; exhausted stays
// - Power loss disturbs at most one bit
// - Host fills bytes only with 2^n-1 patterns
// - Read and write leave bitmap untouched
// - Compare copy path ignores single-use bit
// - Derive limits parent key, not target key
// - Compare returns one true/false result
// - Copy target is slot, or slot+1 if secondary
// - Copy allowed only when target read-key is 0
// - Host keeps read-key nonzero unless copying
// - Copy only in compare mode 0x01
// - Match copies slot, sets scratch register flags
// - Selectors >= 0x8000: transport keys, digest-generate only
// - Low selector nibble picks slot; full selector hashed
// - Host personalizes in the documented order
//
// Design decision made here: the APB interface to the registers.
`include "klp_defs.svh"

module klp_device (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  klp_if.dev                link,
  input  wire logic         single_use15_i,
  input  wire logic [63:0]  read_key_i,
  input  wire logic [255:0] digest_i,
  input  wire logic [255:0] slot_data_i,
  output logic [3:0]        slot_idx_o,
  output logic [15:0]       hash_sel_o,
  output logic              transport_o,
  output logic              run_o,
  output logic [255:0]      scratch_o,
  output logic              scratch_origin_o,
  output logic              scratch_gen_data_o,
  output logic              scratch_cmp_only_o,
  output logic              scratch_valid_o,
  output logic [127:0]      bitmap_o,
  output logic              cfg_locked_o
);
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Read-key field of one slot from the packed slot settings
  function automatic logic [3:0] read_key_of(input logic [63:0] fields,
                                             input logic [3:0]  slot);
    read_key_of = fields[slot * 4 +: 4];
  endfunction : read_key_of

  // Byte k of the bitmap, k = 0 stands for config byte 68
  function automatic logic [7:0] bitmap_byte(input logic [127:0] map,
                                             input logic [3:0]   k);
    bitmap_byte = map[k * 8 +: 8];
  endfunction : bitmap_byte

  // ----------------------------------------------------------------------
  // Latched request
  // ----------------------------------------------------------------------
  klp_pkg::klp_dev_state_e state;
  klp_pkg::klp_cmd_e       cmd_q;
  logic [15:0]             sel_q;
  logic [7:0]              mode_q;
  logic                    sec_q;
  logic [255:0]            resp_q;
  logic [7:0]              wdata_q;
  logic [127:0]            bitmap;
  logic                    found;
  logic [6:0]              pos;

  // Bitmap scan for the next use bit
  klp_first_one u_first_one (
    .map_i   (bitmap),
    .found_o (found),
    .pos_o   (pos)
  );

  // ----------------------------------------------------------------------
  // Verdict of the latched command
  // ----------------------------------------------------------------------
  logic        transport;
  logic        sel_bad;
  logic        crypto;
  logic        limited;
  logic        exhausted;
  logic        cfg_cmd;
  logic        cmp_match;
  logic        copy_mode;
  logic        copy_ok;
  logic [2:0]  verdict;

  always_comb begin
    transport = sel_q >= `KLP_SEL_TRANSPORT;
    sel_bad   = transport && (cmd_q != klp_pkg::CMD_GEN_DIGEST);
    copy_mode = (cmd_q == klp_pkg::CMD_MAC_COMPARE) && (mode_q == `KLP_COPY_MODE);
    // Copy path and read/write do not consume uses; derive checks parent only
    crypto    = (cmd_q == klp_pkg::CMD_MAC) || (cmd_q == klp_pkg::CMD_DERIVE) ||
                (cmd_q == klp_pkg::CMD_GEN_DIGEST) ||
                ((cmd_q == klp_pkg::CMD_MAC_COMPARE) && !copy_mode);
    limited   = crypto && !transport && (sel_q[3:0] == `KLP_KEY15) &&
                single_use15_i;
    exhausted = limited && !found;
    cfg_cmd   = (cmd_q == klp_pkg::CMD_CFG_BYTE) || (cmd_q == klp_pkg::CMD_CFG_LOCK);
    cmp_match = resp_q == digest_i;
    copy_ok   = copy_mode && cmp_match &&
                (read_key_of(read_key_i, slot_idx_o) == 4'h0);
    if (sel_bad) begin
      verdict = `KLP_ST_BAD_SEL;
    end else if (exhausted) begin
      verdict = `KLP_ST_EXHAUSTED;
    end else if (cfg_cmd && cfg_locked_o) begin
      verdict = `KLP_ST_LOCKED;
    end else begin
      verdict = `KLP_ST_OK;
    end
  end

  // ----------------------------------------------------------------------
  // Sequencing and request capture
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state   <= klp_pkg::DEV_IDLE;
      cmd_q   <= klp_pkg::CMD_MAC;
      sel_q   <= 16'h0000;
      mode_q  <= 8'h00;
      sec_q   <= 1'b0;
      resp_q  <= '0;
      wdata_q <= 8'h00;
    end else begin
      case (state)
        klp_pkg::DEV_IDLE: begin
          if (link.req) begin
            cmd_q   <= link.cmd;
            sel_q   <= link.key_sel;
            mode_q  <= link.mode;
            sec_q   <= link.secondary;
            resp_q  <= link.resp;
            wdata_q <= link.wdata;
            state   <= klp_pkg::DEV_EXEC;
          end
        end
        klp_pkg::DEV_EXEC: begin
          state <= klp_pkg::DEV_IDLE;
        end
        default: begin
          state <= klp_pkg::DEV_IDLE;
        end
      endcase
    end
  end

  // Slot address and hash selector for the attached engine
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      slot_idx_o  <= 4'h0;
      hash_sel_o  <= 16'h0000;
      transport_o <= 1'b0;
    end else if (state == klp_pkg::DEV_IDLE && link.req) begin
      // Password slot plus one releases the secondary secret
      if (link.cmd == klp_pkg::CMD_MAC_COMPARE && link.secondary) begin
        slot_idx_o <= link.key_sel[3:0] + 4'h1;
      end else begin
        slot_idx_o <= link.key_sel[3:0];
      end
      hash_sel_o  <= link.key_sel;
      transport_o <= link.key_sel >= `KLP_SEL_TRANSPORT;
    end
  end

  // ----------------------------------------------------------------------
  // Key-15 use bitmap and configuration lock
  // ----------------------------------------------------------------------
  // A use clears one bit in a single write, so an interrupted use can
  // only leave that one bit uncertain
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bitmap <= `KLP_BITMAP_RST;
    end else if (state == klp_pkg::DEV_EXEC && verdict == `KLP_ST_OK) begin
      if (limited) begin
        bitmap[pos] <= 1'b0;
      end else if (cmd_q == klp_pkg::CMD_CFG_BYTE) begin
        bitmap[sel_q[3:0] * 8 +: 8] <= wdata_q;
      end
    end
  end

  // Lock is one-way; nothing reopens the bitmap after it
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_locked_o <= 1'b0;
    end else if (state == klp_pkg::DEV_EXEC && cmd_q == klp_pkg::CMD_CFG_LOCK) begin
      cfg_locked_o <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bitmap_o <= `KLP_BITMAP_RST;
    end else begin
      bitmap_o <= bitmap;
    end
  end

  // ----------------------------------------------------------------------
  // Scratch digest register
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scratch_o          <= '0;
      scratch_origin_o   <= 1'b0;
      scratch_gen_data_o <= 1'b0;
      scratch_cmp_only_o <= 1'b0;
      scratch_valid_o    <= 1'b0;
    end else if (state == klp_pkg::DEV_EXEC && verdict == `KLP_ST_OK && copy_ok) begin
      scratch_o          <= slot_data_i;
      scratch_origin_o   <= 1'b1;
      scratch_gen_data_o <= 1'b0;
      scratch_cmp_only_o <= 1'b0;
      scratch_valid_o    <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Answer to the controller and go-ahead to the engine
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      link.done   <= 1'b0;
      link.status <= `KLP_ST_OK;
      link.match  <= 1'b0;
      link.rdata  <= 8'h00;
      run_o       <= 1'b0;
    end else begin
      link.done <= state == klp_pkg::DEV_EXEC;
      run_o     <= state == klp_pkg::DEV_EXEC && verdict == `KLP_ST_OK && crypto;
      if (state == klp_pkg::DEV_EXEC) begin
        link.status <= verdict;
        link.match  <= (cmd_q == klp_pkg::CMD_MAC_COMPARE) &&
                       verdict == `KLP_ST_OK && cmp_match;
        link.rdata  <= (cmd_q == klp_pkg::CMD_READ) ?
                       bitmap_byte(bitmap, sel_q[3:0]) : 8'h00;
      end
    end
  end
endmodule : klp_device

// ---- rtl/klp_first_one.sv ----
// Finds the first set bit: byte 0 before byte 15, bit 7 before bit 0
module klp_first_one (
  input  wire logic [127:0] map_i,
  output logic              found_o,
  output logic [6:0]        pos_o
);
  logic [127:0] hit;

  // One-hot of the winning bit: no set bit earlier in scan order
  genvar g;
  generate
    for (g = 0; g < 128; g = g + 1) begin : g_scan
      localparam int BYTE = g / 8;
      localparam int ORD  = BYTE * 8 + (7 - g % 8);
      if (ORD == 0) begin : g_first
        assign hit[g] = map_i[g];
      end else begin : g_rest
        logic [127:0] earlier;
        always_comb begin
          earlier = '0;
          for (int k = 0; k < 128; k = k + 1) begin
            if ((k / 8) * 8 + (7 - k % 8) < ORD) begin
              earlier[k] = map_i[k];
            end
          end
        end
        assign hit[g] = map_i[g] & ~(|earlier);
      end
    end
  endgenerate

  // Encode the one-hot winner
  always_comb begin
    pos_o = 7'h00;
    for (int i = 0; i < 128; i = i + 1) begin
      if (hit[i]) begin
        pos_o = 7'(i);
      end
    end
    found_o = |map_i;
  end
endmodule : klp_first_one

// ---- rtl/klp_host.sv ----
`include "klp_defs.svh"

module klp_host (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  klp_if.host              link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic [31:0]          resp_mem [8];
  logic [2:0]           resp_idx;
  logic [15:0]          sel;
  logic                 busy;
  logic                 locked;
  klp_pkg::klp_status_t last_status;
  logic                 last_match;
  logic [7:0]           last_rdata;
  logic                 wr_access;
  logic [31:0]          ctrl_w;
  klp_pkg::klp_cmd_e    ctrl_cmd;
  logic [7:0]           fill;
  logic                 legal_fill;
  logic                 order_bad;

  // Bitmap fill must be all ones from bit 0 upward
  always_comb begin
    wr_access  = psel && penable && pready && pwrite;
    ctrl_w     = pwdata;
    ctrl_cmd   = klp_pkg::klp_cmd_e'(ctrl_w[`KLP_CTRL_CMD_LSB +: 4]);
    fill       = ctrl_w[`KLP_CTRL_VAL_LSB +: 8];
    legal_fill = (fill & (fill + 8'h01)) == 8'h00;
    // Configuration and reads first, then data and crypto work
    order_bad  = locked ? (ctrl_cmd == klp_pkg::CMD_CFG_BYTE ||
                           ctrl_cmd == klp_pkg::CMD_CFG_LOCK)
                        : !(ctrl_cmd == klp_pkg::CMD_CFG_BYTE ||
                            ctrl_cmd == klp_pkg::CMD_CFG_LOCK ||
                            ctrl_cmd == klp_pkg::CMD_READ);
  end

  // ----------------------------------------------------------------------
  // APB slave timing: one wait-free access cycle
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable && !pready;
      pslverr <= psel && !penable && !pready &&
                 !(paddr == `KLP_REG_CTRL || paddr == `KLP_REG_SEL ||
                   paddr == `KLP_REG_RESP_IDX || paddr == `KLP_REG_RESP_DATA ||
                   paddr == `KLP_REG_STATUS);
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `KLP_REG_SEL:       prdata <= {16'h0000, sel};
          `KLP_REG_RESP_IDX:  prdata <= {29'h0, resp_idx};
          `KLP_REG_RESP_DATA: prdata <= resp_mem[resp_idx];
          `KLP_REG_STATUS:    prdata <= {16'h0000, last_rdata, 2'b00, locked,
                                         last_match, last_status, busy};
          default:            prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Selector and response words
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sel      <= 16'h0000;
      resp_idx <= 3'h0;
      for (int i = 0; i < 8; i = i + 1) begin
        resp_mem[i] <= 32'h0000_0000;
      end
    end else if (wr_access) begin
      case (paddr)
        `KLP_REG_SEL:       sel <= pwdata[15:0];
        `KLP_REG_RESP_IDX:  resp_idx <= pwdata[2:0];
        `KLP_REG_RESP_DATA: resp_mem[resp_idx] <= pwdata;
        default:            ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Command launch and completion
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy           <= 1'b0;
      locked         <= 1'b0;
      last_status    <= `KLP_ST_OK;
      last_match     <= 1'b0;
      last_rdata     <= 8'h00;
      link.req       <= 1'b0;
      link.cmd       <= klp_pkg::CMD_MAC;
      link.key_sel   <= 16'h0000;
      link.mode      <= 8'h00;
      link.secondary <= 1'b0;
      link.resp      <= '0;
      link.wdata     <= 8'h00;
    end else begin
      link.req <= 1'b0;
      if (busy && link.done) begin
        busy        <= 1'b0;
        last_status <= link.status;
        last_match  <= link.match;
        last_rdata  <= link.rdata;
        if (link.cmd == klp_pkg::CMD_CFG_LOCK && link.status == `KLP_ST_OK) begin
          locked <= 1'b1;
        end
      end else if (wr_access && paddr == `KLP_REG_CTRL && !busy) begin
        if (order_bad) begin
          last_status <= `KLP_ST_ORDER;
        end else if (ctrl_cmd == klp_pkg::CMD_CFG_BYTE && !legal_fill) begin
          last_status <= `KLP_ST_BAD_VALUE;
        end else begin
          busy           <= 1'b1;
          link.req       <= 1'b1;
          link.cmd       <= ctrl_cmd;
          link.key_sel   <= sel;
          link.mode      <= ctrl_w[`KLP_CTRL_MODE_LSB +: 8];
          link.secondary <= ctrl_w[`KLP_CTRL_SEC_BIT];
          link.wdata     <= fill;
          for (int i = 0; i < 8; i = i + 1) begin
            link.resp[i * 32 +: 32] <= resp_mem[i];
          end
        end
      end
    end
  end
endmodule : klp_host

// ---- shared/klp_defs.svh ----
`ifndef KLP_DEFS_SVH
`define KLP_DEFS_SVH
// ----------------------------------------------------------------------
// Key-15 use bitmap
// ----------------------------------------------------------------------
`define KLP_BITMAP_W        128
`define KLP_BITMAP_BYTES    16
`define KLP_BITMAP_OFFSET   8'h44
`define KLP_BITMAP_RST      128'h0
`define KLP_BYTE_ALL_ONES   8'hFF
// ----------------------------------------------------------------------
// Selectors, modes, widths
// ----------------------------------------------------------------------
`define KLP_DIGEST_W        256
`define KLP_SEL_TRANSPORT   16'h8000
`define KLP_KEY15           4'hF
`define KLP_COPY_MODE       8'h01
`define KLP_READ_KEY_W      4
// ----------------------------------------------------------------------
// Status codes
// ----------------------------------------------------------------------
`define KLP_ST_OK           3'h0
`define KLP_ST_EXHAUSTED    3'h1
`define KLP_ST_BAD_SEL      3'h2
`define KLP_ST_LOCKED       3'h3
`define KLP_ST_BAD_VALUE    3'h4
`define KLP_ST_ORDER        3'h5
// ----------------------------------------------------------------------
// Controller APB map
// ----------------------------------------------------------------------
`define KLP_REG_CTRL        8'h00
`define KLP_REG_SEL         8'h04
`define KLP_REG_RESP_IDX    8'h08
`define KLP_REG_RESP_DATA   8'h0C
`define KLP_REG_STATUS      8'h10
`define KLP_CTRL_CMD_LSB    0
`define KLP_CTRL_SEC_BIT    4
`define KLP_CTRL_MODE_LSB   8
`define KLP_CTRL_VAL_LSB    16
`endif

// ---- shared/klp_if.sv ----
interface klp_if;
  logic                 req;
  klp_pkg::klp_cmd_e    cmd;
  logic [15:0]          key_sel;
  logic [7:0]           mode;
  logic                 secondary;
  logic [255:0]         resp;
  logic [7:0]           wdata;
  logic                 done;
  klp_pkg::klp_status_t status;
  logic                 match;
  logic [7:0]           rdata;

  modport dev (
    input  req, cmd, key_sel, mode, secondary, resp, wdata,
    output done, status, match, rdata
  );
  modport host (
    output req, cmd, key_sel, mode, secondary, resp, wdata,
    input  done, status, match, rdata
  );
endinterface : klp_if

// ---- shared/klp_pkg.sv ----
package klp_pkg;
  // Commands carried from controller to device
  typedef enum logic [3:0] {
    CMD_MAC         = 4'h0,
    CMD_MAC_COMPARE = 4'h1,
    CMD_DERIVE      = 4'h2,
    CMD_GEN_DIGEST  = 4'h3,
    CMD_READ        = 4'h4,
    CMD_WRITE       = 4'h5,
    CMD_CFG_BYTE    = 4'h6,
    CMD_CFG_LOCK    = 4'h7
  } klp_cmd_e;

  // Device sequencing
  typedef enum logic [1:0] {
    DEV_IDLE = 2'b00,
    DEV_EXEC = 2'b01
  } klp_dev_state_e;

  typedef logic [2:0] klp_status_t;
endpackage : klp_pkg
